// File: gate_service.sv
// maintenance, override, viewing and factory reset logic of the gate unit
`timescale 1ns/10ps
module gate_service
  import gate_service_pkg::*;
#(
  parameter int CNT_W = 24,
  parameter int unsigned ARM_WINDOW = ARM_WINDOW_CYC,
  parameter int unsigned ARM_DELAY = ARM_DELAY_CYC,
  parameter int unsigned VIEW_DELAY = VIEW_DELAY_CYC,
  parameter int unsigned ENTER_HOLD = ENTER_HOLD_CYC,
  parameter int unsigned RESET_HOLD = RESET_HOLD_CYC,
  parameter int unsigned RESET_FLASH = RESET_FLASH_CYC,
  parameter int unsigned MAINT_LIT = MAINT_LIT_CYC,
  parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
  parameter int unsigned COUNT_HALF = COUNT_HALF_CYC,
  parameter int unsigned FAST_HALF = FAST_HALF_CYC,
  parameter int unsigned FAULT_HALF = FAULT_HALF_CYC,
  parameter int unsigned FAULT_PAUSE = FAULT_PAUSE_CYC
)
(
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  // panel buttons
  input wire logic SET_BTN_IN,
  input wire logic OPEN_BTN_IN,
  input wire logic CLOSE_BTN_IN,
  // movement command and safety state
  input wire logic MOVE_CMD_IN,
  input wire logic SAFETY_FAIL_IN,
  input wire gate_service_pkg::fault_cat_t FAULT_CAT_IN,
  // manoeuvre events
  input wire logic MANOEUVRE_START_IN,
  input wire logic MANOEUVRE_OPENING_IN,
  input wire logic MANOEUVRE_ACTIVE_IN,
  input wire logic MANOEUVRE_DONE_IN,
  input wire gate_service_pkg::fault_cat_t MANOEUVRE_RESULT_IN,
  // output role configuration and maintenance level write
  input wire logic MAINT_ON_WARN_IN,
  input wire logic MAINT_ON_AUX_IN,
  input wire logic AUX_LOCK_REQ_IN,
  input wire logic LEVEL_WRITE_IN,
  input wire logic [2:0] LEVEL_VALUE_IN,
  // indicators and drives
  output logic [7:0] PROGRAM_LED_OUT,
  output logic WARN_LAMP_OUT,
  output logic AUX_LOCK_OUT,
  output logic HOLD_RUN_OUT,
  output logic FACTORY_CLEAR_OUT,
  // status
  output logic [2:0] MAINT_LEVEL_OUT,
  output logic [CNT_W-1:0] MANOEUVRE_COUNT_OUT,
  output gate_service_pkg::log_flags_t ANOMALY_FLAGS_OUT
);
  import gate_service_pkg::*;

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  // the counter must reach past the largest limit and the percent product fits 32 bits
  if (CNT_W < 16 || CNT_W > 27)
  begin : g_bad_width
    $error("CNT_W must lie between 16 and 27");
  end
  if (ARM_WINDOW == 0 || ARM_DELAY == 0 || VIEW_DELAY == 0 || SLOW_HALF == 0 ||
      COUNT_HALF == 0 || FAST_HALF == 0 || FAULT_HALF == 0 || FAULT_PAUSE == 0)
  begin : g_bad_time
    $error("timing counts must be at least one cycle");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    UI_IDLE = 4'h0,
    UI_ENTER = 4'h1,
    UI_SELECT = 4'h2,
    UI_VIEW_WAIT = 4'h3,
    UI_VIEW_LEVEL = 4'h4,
    UI_VIEW_PCT = 4'h5,
    UI_RST_HOLD = 4'h6,
    UI_RST_LIT = 4'h7,
    UI_RST_FLASH = 4'h8
  } ui_state_t;

  typedef enum logic [1:0] {
    MV_IDLE = 2'h0,
    MV_REFUSED = 2'h1,
    MV_ARMING = 2'h2,
    MV_RUN = 2'h3
  } mv_state_t;

  typedef struct packed {
    ui_state_t ui;
    logic [31:0] ui_tmr;
    logic [2:0] sel;
    logic [2:0] lvl;
    logic [CNT_W-1:0] cnt;
    logic [3:0] pct_left;
    logic pct_on;
    logic fast;
    logic [31:0] fast_tmr;
    mv_state_t mv;
    logic [31:0] mv_tmr;
    logic [3:0] lamp_left;
    logic lamp_on;
    logic [31:0] lamp_tmr;
    logic [31:0] blink_tmr;
    logic blink;
    logic [31:0] maint_tmr;
    logic set_p;
    logic open_p;
    logic close_p;
    logic cmd_p;
    logic [7:0] led;
    logic warn;
    logic aux;
    logic hold_run;
    logic fclear;
  } svc_state_t;

  svc_state_t s_q;
  svc_state_t s_d;

  anomaly_log_if lg ();

  anomaly_log u_log (
    .clk(CORE_CLK_IN),
    .rst(SYS_RST_IN),
    .lg(lg)
  );

  // ---------------------------------------------------------------
  // derived values
  // ---------------------------------------------------------------
  logic [31:0] cnt_w;
  logic [31:0] lim_w;
  logic [3:0] decades;
  logic band_low;
  logic band_over;
  logic maint_sig;
  logic set_rise;
  logic open_rise;
  logic close_rise;
  logic cmd_rise;
  logic both_btn;

  assign cnt_w = 32'(s_q.cnt);
  assign lim_w = 32'(limit_of(s_q.lvl));
  assign band_low = (cnt_w * 32'd5) < (lim_w * 32'd4);
  assign band_over = cnt_w > lim_w;
  assign set_rise = SET_BTN_IN && !s_q.set_p;
  assign open_rise = OPEN_BTN_IN && !s_q.open_p;
  assign close_rise = CLOSE_BTN_IN && !s_q.close_p;
  assign cmd_rise = MOVE_CMD_IN && !s_q.cmd_p;
  assign both_btn = OPEN_BTN_IN && CLOSE_BTN_IN;

  // whole tenths of the limit, rounded down; fewer than one gives zero
  always_comb
  begin
    decades = 4'h0;
    for (int k = 1; k <= 15; k++)
    begin
      if (cnt_w * 32'd10 >= lim_w * 32'(k))
      begin
        decades = 4'(k);
      end
    end
  end

  always_comb
  begin
    if (band_over)
    begin
      maint_sig = s_q.blink;
    end
    else if (!band_low)
    begin
      maint_sig = MANOEUVRE_ACTIVE_IN && s_q.blink;
    end
    else
    begin
      maint_sig = s_q.maint_tmr != 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.set_p = SET_BTN_IN;
    s_d.open_p = OPEN_BTN_IN;
    s_d.close_p = CLOSE_BTN_IN;
    s_d.cmd_p = MOVE_CMD_IN;
    s_d.fclear = 1'b0;
    s_d.ui_tmr = s_q.ui_tmr + 32'h1;

    // free-running slow and fast blink sources
    s_d.blink_tmr = s_q.blink_tmr + 32'h1;
    if (s_q.blink_tmr >= SLOW_HALF - 1)
    begin
      s_d.blink_tmr = 32'h0;
      s_d.blink = !s_q.blink;
    end
    s_d.fast_tmr = s_q.fast_tmr + 32'h1;
    if (s_q.fast_tmr >= FAST_HALF - 1)
    begin
      s_d.fast_tmr = 32'h0;
      s_d.fast = !s_q.fast;
    end

    // manoeuvre counting and the steady start-of-opening light
    if (MANOEUVRE_DONE_IN && s_q.cnt != '1)
    begin
      s_d.cnt = s_q.cnt + CNT_W'(1);
    end
    if (MANOEUVRE_START_IN && MANOEUVRE_OPENING_IN)
    begin
      s_d.maint_tmr = MAINT_LIT;
    end
    else if (s_q.maint_tmr != 32'h0)
    begin
      s_d.maint_tmr = s_q.maint_tmr - 32'h1;
    end
    if (LEVEL_WRITE_IN)
    begin
      s_d.lvl = LEVEL_VALUE_IN;
    end

    // ---- operator panel ----
    unique case (s_q.ui)
      UI_IDLE:
      begin
        s_d.ui_tmr = 32'h0;
        if (both_btn)
        begin
          s_d.ui = UI_RST_HOLD;
        end
        else if (SET_BTN_IN)
        begin
          s_d.ui = UI_ENTER;
        end
      end
      UI_ENTER:
      begin
        if (!SET_BTN_IN)
        begin
          s_d.ui = UI_IDLE;
        end
        else if (s_q.ui_tmr >= ENTER_HOLD - 1)
        begin
          s_d.ui = UI_SELECT;
          s_d.sel = ENTRY_POS;
        end
      end
      UI_SELECT:
      begin
        s_d.ui_tmr = 32'h0;
        if (open_rise)
        begin
          s_d.sel = s_q.sel + 3'h1;
        end
        else if (close_rise)
        begin
          s_d.sel = s_q.sel - 3'h1;
        end
        else if (set_rise)
        begin
          s_d.ui = (s_q.sel == MAINT_PARAM_POS) ? UI_VIEW_WAIT : UI_IDLE;
        end
      end
      UI_VIEW_WAIT:
      begin
        if (!SET_BTN_IN)
        begin
          s_d.ui = UI_SELECT;
        end
        else if (s_q.ui_tmr >= VIEW_DELAY - 1)
        begin
          s_d.ui = UI_VIEW_LEVEL;
        end
      end
      UI_VIEW_LEVEL:
      begin
        s_d.ui_tmr = 32'h0;
        if (!SET_BTN_IN)
        begin
          s_d.ui = UI_SELECT;
        end
        else if (both_btn && (open_rise || close_rise))
        begin
          s_d.ui = UI_VIEW_PCT;
          s_d.pct_left = decades;
          s_d.pct_on = 1'b0;
        end
      end
      UI_VIEW_PCT:
      begin
        if (!SET_BTN_IN)
        begin
          s_d.ui = UI_SELECT;
        end
        else if (s_q.pct_left == 4'h0 && !s_q.pct_on)
        begin
          s_d.ui = UI_VIEW_LEVEL;
        end
        else if (s_q.ui_tmr >= COUNT_HALF - 1)
        begin
          s_d.ui_tmr = 32'h0;
          s_d.pct_on = !s_q.pct_on;
          if (s_q.pct_on)
          begin
            s_d.pct_left = s_q.pct_left - 4'h1;
          end
        end
      end
      UI_RST_HOLD:
      begin
        if (!both_btn)
        begin
          s_d.ui = UI_IDLE;
        end
        else if (s_q.ui_tmr >= RESET_HOLD - 1)
        begin
          s_d.ui = UI_RST_LIT;
        end
      end
      UI_RST_LIT:
      begin
        s_d.ui_tmr = 32'h0;
        // the erase fires only once both buttons are let go
        if (!OPEN_BTN_IN && !CLOSE_BTN_IN)
        begin
          s_d.ui = UI_RST_FLASH;
          s_d.fclear = 1'b1;
          s_d.lvl = MAINT_LEVEL_DEFAULT;
        end
      end
      UI_RST_FLASH:
      begin
        if (s_q.ui_tmr >= RESET_FLASH - 1)
        begin
          s_d.ui = UI_IDLE;
        end
      end
      default:
      begin
        s_d.ui = UI_IDLE;
      end
    endcase

    unique case (s_d.ui)
      UI_SELECT, UI_VIEW_WAIT: s_d.led = s_q.blink ? (8'h01 << s_d.sel) : 8'h00;
      UI_VIEW_LEVEL: s_d.led = 8'h01 << s_d.lvl;
      UI_VIEW_PCT: s_d.led = s_d.pct_on ? (8'h01 << s_d.lvl) : 8'h00;
      UI_RST_LIT: s_d.led = ALL_LEDS;
      UI_RST_FLASH: s_d.led = s_q.fast ? ALL_LEDS : 8'h00;
      default: s_d.led = 8'h00;
    endcase

    // ---- move-anyway override ----
    s_d.mv_tmr = s_q.mv_tmr + 32'h1;
    unique case (s_q.mv)
      MV_IDLE:
      begin
        s_d.mv_tmr = 32'h0;
        if (cmd_rise && SAFETY_FAIL_IN)
        begin
          s_d.mv = MV_REFUSED;
        end
      end
      MV_REFUSED:
      begin
        if (s_q.mv_tmr >= ARM_WINDOW - 1)
        begin
          s_d.mv = MV_IDLE;
        end
        else if (cmd_rise)
        begin
          s_d.mv = MV_ARMING;
          s_d.mv_tmr = 32'h0;
        end
      end
      MV_ARMING:
      begin
        if (!MOVE_CMD_IN)
        begin
          s_d.mv = MV_IDLE;
        end
        else if (s_q.mv_tmr >= ARM_DELAY - 1)
        begin
          s_d.mv = MV_RUN;
        end
      end
      MV_RUN:
      begin
        if (!MOVE_CMD_IN)
        begin
          s_d.mv = MV_IDLE;
        end
      end
    endcase
    s_d.hold_run = (s_d.mv == MV_RUN);

    // ---- fault category flashes: n short flashes then a pause ----
    if (!SAFETY_FAIL_IN)
    begin
      s_d.lamp_left = 4'h0;
      s_d.lamp_on = 1'b0;
      s_d.lamp_tmr = 32'h0;
    end
    else if (s_q.lamp_left == 4'h0 && !s_q.lamp_on)
    begin
      s_d.lamp_tmr = s_q.lamp_tmr + 32'h1;
      if (s_q.lamp_tmr >= FAULT_PAUSE - 1)
      begin
        s_d.lamp_tmr = 32'h0;
        s_d.lamp_left = FAULT_CAT_IN;
      end
    end
    else
    begin
      s_d.lamp_tmr = s_q.lamp_tmr + 32'h1;
      if (s_q.lamp_tmr >= FAULT_HALF - 1)
      begin
        s_d.lamp_tmr = 32'h0;
        s_d.lamp_on = !s_q.lamp_on;
        if (!s_q.lamp_on)
        begin
          s_d.lamp_left = s_q.lamp_left - 4'h1;
        end
      end
    end

    s_d.warn = SAFETY_FAIL_IN ? s_d.lamp_on : (MAINT_ON_WARN_IN && maint_sig);
    s_d.aux = MAINT_ON_AUX_IN ? maint_sig : AUX_LOCK_REQ_IN;
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      s_q <= '0;
      s_q.lvl <= MAINT_LEVEL_DEFAULT;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // log hookup and outputs
  // ---------------------------------------------------------------
  assign lg.push = MANOEUVRE_DONE_IN;
  assign lg.cat = MANOEUVRE_RESULT_IN;
  assign lg.clear = s_q.fclear;

  assign PROGRAM_LED_OUT = s_q.led;
  assign WARN_LAMP_OUT = s_q.warn;
  assign AUX_LOCK_OUT = s_q.aux;
  assign HOLD_RUN_OUT = s_q.hold_run;
  assign FACTORY_CLEAR_OUT = s_q.fclear;
  assign MAINT_LEVEL_OUT = s_q.lvl;
  assign MANOEUVRE_COUNT_OUT = s_q.cnt;
  assign ANOMALY_FLAGS_OUT = lg.flags;
endmodule

// File: gate_service_pkg.sv
// constants, types and helpers shared by the gate service logic
package gate_service_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned ARM_WINDOW_MS = 3000;
  localparam int unsigned ARM_DELAY_MS = 2000;
  localparam int unsigned VIEW_DELAY_MS = 3000;
  localparam int unsigned ENTER_HOLD_MS = 3000;
  localparam int unsigned RESET_HOLD_MS = 3000;
  localparam int unsigned RESET_FLASH_MS = 3000;
  localparam int unsigned MAINT_LIT_MS = 2000;
  localparam int unsigned SLOW_HALF_MS = 500;
  localparam int unsigned COUNT_HALF_MS = 250;
  localparam int unsigned FAST_HALF_MS = 100;
  localparam int unsigned FAULT_HALF_MS = 150;
  localparam int unsigned FAULT_PAUSE_MS = 1000;
  localparam int unsigned ARM_WINDOW_CYC = ARM_WINDOW_MS * CYC_PER_MS;
  localparam int unsigned ARM_DELAY_CYC = ARM_DELAY_MS * CYC_PER_MS;
  localparam int unsigned VIEW_DELAY_CYC = VIEW_DELAY_MS * CYC_PER_MS;
  localparam int unsigned ENTER_HOLD_CYC = ENTER_HOLD_MS * CYC_PER_MS;
  localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_MS * CYC_PER_MS;
  localparam int unsigned RESET_FLASH_CYC = RESET_FLASH_MS * CYC_PER_MS;
  localparam int unsigned MAINT_LIT_CYC = MAINT_LIT_MS * CYC_PER_MS;
  localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_MS * CYC_PER_MS;
  localparam int unsigned COUNT_HALF_CYC = COUNT_HALF_MS * CYC_PER_MS;
  localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * CYC_PER_MS;
  localparam int unsigned FAULT_HALF_CYC = FAULT_HALF_MS * CYC_PER_MS;
  localparam int unsigned FAULT_PAUSE_CYC = FAULT_PAUSE_MS * CYC_PER_MS;

  // ---------------------------------------------------------------
  // settings and log
  // ---------------------------------------------------------------
  localparam int LOG_DEPTH = 8;
  localparam int CAT_W = 4;
  localparam int LED_COUNT = 8;
  localparam logic [2:0] MAINT_LEVEL_DEFAULT = 3'h5;
  localparam logic [2:0] MAINT_PARAM_POS = 3'h6;
  localparam logic [2:0] ENTRY_POS = 3'h0;
  localparam logic [3:0] MAX_DECADES = 4'hF;
  localparam logic [7:0] ALL_LEDS = 8'hFF;

  typedef logic [LOG_DEPTH-1:0] log_flags_t;
  typedef logic [CAT_W-1:0] fault_cat_t;

  // level index 0 is LED one; the limit rises with the level
  function automatic logic [15:0] limit_of(input logic [2:0] lvl);
    logic [15:0] lim;
    unique case (lvl)
      3'h0: lim = 16'h01F4;
      3'h1: lim = 16'h03E8;
      3'h2: lim = 16'h05DC;
      3'h3: lim = 16'h09C4;
      3'h4: lim = 16'h1388;
      3'h5: lim = 16'h2710;
      3'h6: lim = 16'h3A98;
      3'h7: lim = 16'h4E20;
    endcase
    return lim;
  endfunction

endpackage

// File: anomaly_log_if.sv
// carrier between the service logic and its anomaly log
`timescale 1ns/10ps
interface anomaly_log_if;
  import gate_service_pkg::*;
  logic push;
  fault_cat_t cat;
  logic clear;
  log_flags_t flags;
  modport owner (output push, output cat, output clear, input flags);
  modport store (input push, input cat, input clear, output flags);
endinterface

// File: anomaly_log.sv
// eight-entry anomaly log, newest result at position zero
`timescale 1ns/10ps
module anomaly_log
  import gate_service_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // log port
  anomaly_log_if.store lg
);
  typedef struct packed {
    logic [LOG_DEPTH-1:0][CAT_W-1:0] cat;
    log_flags_t flags;
  } log_state_t;

  log_state_t s_q;
  log_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (lg.clear)
    begin
      s_d.cat = '0;
    end
    // a result landing with the clear survives it
    if (lg.push)
    begin
      s_d.cat = {s_d.cat[LOG_DEPTH-2:0], lg.cat};
    end
    for (int i = 0; i < LOG_DEPTH; i++)
    begin
      s_d.flags[i] = |s_d.cat[i];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign lg.flags = s_q.flags;
endmodule

// File: gate_service_asserts.sv
// concurrent checks on the gate service ports
`timescale 1ns/10ps
module gate_service_asserts
  import gate_service_pkg::*;
#(
  parameter int CNT_W = 24,
  parameter int unsigned ARM_DELAY = 20,
  parameter int unsigned RESET_HOLD = 20,
  parameter int unsigned SLOW_HALF = 4
)
(
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  // watched inputs
  input wire logic OPEN_BTN_IN,
  input wire logic CLOSE_BTN_IN,
  input wire logic MOVE_CMD_IN,
  input wire logic SAFETY_FAIL_IN,
  input wire logic MANOEUVRE_DONE_IN,
  input wire gate_service_pkg::fault_cat_t MANOEUVRE_RESULT_IN,
  input wire logic MAINT_ON_WARN_IN,
  input wire logic MAINT_ON_AUX_IN,
  input wire logic AUX_LOCK_REQ_IN,
  input wire logic LEVEL_WRITE_IN,
  input wire logic [2:0] LEVEL_VALUE_IN,
  // watched outputs
  input wire logic [7:0] PROGRAM_LED_OUT,
  input wire logic WARN_LAMP_OUT,
  input wire logic AUX_LOCK_OUT,
  input wire logic HOLD_RUN_OUT,
  input wire logic FACTORY_CLEAR_OUT,
  input wire logic [2:0] MAINT_LEVEL_OUT,
  input wire logic [CNT_W-1:0] MANOEUVRE_COUNT_OUT,
  input wire gate_service_pkg::log_flags_t ANOMALY_FLAGS_OUT
);
  // ----------------------------------------
  // run-length counters
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] cmd_run;
    logic [15:0] both_run;
    logic [15:0] aux_same;
    logic [15:0] over_run;
    logic aux_prev;
  } watch_t;
  watch_t w_q, w_d;
  always_comb
  begin
    w_d = w_q;
    w_d.cmd_run = MOVE_CMD_IN ? w_q.cmd_run + 16'h0001 : 16'h0000;
    w_d.both_run = (OPEN_BTN_IN && CLOSE_BTN_IN) ? w_q.both_run + 16'h0001 : 16'h0000;
    w_d.aux_same = (AUX_LOCK_OUT == w_q.aux_prev) ? w_q.aux_same + 16'h0001 : 16'h0000;
    w_d.aux_prev = AUX_LOCK_OUT;
    // stale blink history is ignored until the over-limit band has lasted a while
    w_d.over_run = (MAINT_ON_AUX_IN && MANOEUVRE_COUNT_OUT > limit_of(MAINT_LEVEL_OUT)) ?
      w_q.over_run + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SYS_RST_IN)
      w_q <= '0;
    else
      w_q <= w_d;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  a_log_newest_first: assert property (MANOEUVRE_DONE_IN |=> ANOMALY_FLAGS_OUT ==
    {$past(ANOMALY_FLAGS_OUT[6:0]), $past(MANOEUVRE_RESULT_IN) != 4'h0})
    else $error("log did not shift in newest result");
  a_count_step: assert property (MANOEUVRE_DONE_IN && !(&MANOEUVRE_COUNT_OUT) |=>
    MANOEUVRE_COUNT_OUT == $past(MANOEUVRE_COUNT_OUT) + 1'b1)
    else $error("manoeuvre count did not step by one");
  a_aux_follows_req: assert property (!MAINT_ON_AUX_IN |=>
    AUX_LOCK_OUT == $past(AUX_LOCK_REQ_IN))
    else $error("aux output left its normal role");
  a_warn_role_off: assert property (!SAFETY_FAIL_IN && !MAINT_ON_WARN_IN |=>
    !WARN_LAMP_OUT)
    else $error("warning lamp lit without a role");
  a_hold_drop: assert property (!MOVE_CMD_IN |=> !HOLD_RUN_OUT)
    else $error("hold-to-run kept without command");
  a_hold_after_delay: assert property ($rose(HOLD_RUN_OUT) |->
    w_q.cmd_run >= ARM_DELAY - 1)
    else $error("hold-to-run started too early");
  a_reset_lights_all: assert property (w_q.both_run == RESET_HOLD + 3 |->
    PROGRAM_LED_OUT == ALL_LEDS)
    else $error("leds not all lit after long hold");
  a_clear_restores: assert property ($rose(FACTORY_CLEAR_OUT) |=> !FACTORY_CLEAR_OUT &&
    MAINT_LEVEL_OUT == MAINT_LEVEL_DEFAULT && ANOMALY_FLAGS_OUT == '0)
    else $error("factory clear did not restore defaults");
  a_over_blinks: assert property (w_q.over_run > 2 * SLOW_HALF + 4 |->
    w_q.aux_same <= SLOW_HALF + 2)
    else $error("no blink above the limit");
  a_level_load: assert property (LEVEL_WRITE_IN |=>
    MAINT_LEVEL_OUT == $past(LEVEL_VALUE_IN))
    else $error("level write not taken");
  c_hold_run: cover property ($rose(HOLD_RUN_OUT));
  c_factory: cover property ($rose(FACTORY_CLEAR_OUT));
  c_over: cover property (w_q.over_run > 20);
endmodule

bind gate_service gate_service_asserts #(.CNT_W(CNT_W), .ARM_DELAY(ARM_DELAY),
  .RESET_HOLD(RESET_HOLD), .SLOW_HALF(SLOW_HALF)) gate_service_asserts_inst (
  .CORE_CLK_IN(CORE_CLK_IN), .SYS_RST_IN(SYS_RST_IN), .OPEN_BTN_IN(OPEN_BTN_IN),
  .CLOSE_BTN_IN(CLOSE_BTN_IN), .MOVE_CMD_IN(MOVE_CMD_IN), .SAFETY_FAIL_IN(SAFETY_FAIL_IN),
  .MANOEUVRE_DONE_IN(MANOEUVRE_DONE_IN), .MANOEUVRE_RESULT_IN(MANOEUVRE_RESULT_IN),
  .MAINT_ON_WARN_IN(MAINT_ON_WARN_IN), .MAINT_ON_AUX_IN(MAINT_ON_AUX_IN),
  .AUX_LOCK_REQ_IN(AUX_LOCK_REQ_IN), .LEVEL_WRITE_IN(LEVEL_WRITE_IN),
  .LEVEL_VALUE_IN(LEVEL_VALUE_IN), .PROGRAM_LED_OUT(PROGRAM_LED_OUT),
  .WARN_LAMP_OUT(WARN_LAMP_OUT), .AUX_LOCK_OUT(AUX_LOCK_OUT), .HOLD_RUN_OUT(HOLD_RUN_OUT),
  .FACTORY_CLEAR_OUT(FACTORY_CLEAR_OUT), .MAINT_LEVEL_OUT(MAINT_LEVEL_OUT),
  .MANOEUVRE_COUNT_OUT(MANOEUVRE_COUNT_OUT), .ANOMALY_FLAGS_OUT(ANOMALY_FLAGS_OUT));

// File: panel_operator.sv
// operator model: panel buttons and the movement command
`timescale 1ns/10ps
module panel_operator
(
  // clock
  input wire logic clk_in,
  // button levels
  output logic set_out,
  output logic open_out,
  output logic close_out,
  output logic move_out
);
  initial
  begin
    {move_out, close_out, open_out, set_out} = 4'h0;
  end
  // ----------------------------------------
  // press, hold n cycles, then fall back to rest
  // ----------------------------------------
  // the hold is a fixed count of n cycles; no lamp or output is watched before letting go
  task automatic press(input logic [3:0] btn, input int n, input logic [3:0] rest);
    @(negedge clk_in);
    {move_out, close_out, open_out, set_out} = btn;
    repeat (n) @(negedge clk_in);
    {move_out, close_out, open_out, set_out} = rest;
  endtask
endmodule

// File: test_gate_service.sv
// self-checking bench for the gate service logic
`timescale 1ns/10ps
module test_gate_service;
  import gate_service_pkg::*;
  localparam int HLD = 20;
  localparam int DLY = 20;
  localparam int LIT = 25;
  localparam logic [3:0] S = 4'h1;
  localparam logic [3:0] O = 4'h2;
  localparam logic [3:0] C = 4'h4;
  localparam logic [3:0] M = 4'h8;
  logic clk, rst, set_b, open_b, close_b, move_b, fail, start, opening, active, done;
  logic on_warn, on_aux, aux_req, lvl_wr, warn, aux, hold_run, fclr;
  fault_cat_t fcat, res;
  logic [2:0] lvl_val, lvl;
  logic [7:0] leds, o;
  logic [15:0] cnt;
  log_flags_t flags, ef;
  int fails, total_checks, ec, r, f, k;
  gate_service #(.CNT_W(16), .ARM_WINDOW(30), .ARM_DELAY(DLY), .VIEW_DELAY(HLD),
    .ENTER_HOLD(HLD), .RESET_HOLD(HLD), .RESET_FLASH(30), .MAINT_LIT(LIT), .SLOW_HALF(4),
    .COUNT_HALF(3), .FAST_HALF(2), .FAULT_HALF(2), .FAULT_PAUSE(10)) gate_service_inst (
    .CORE_CLK_IN(clk), .SYS_RST_IN(rst), .SET_BTN_IN(set_b), .OPEN_BTN_IN(open_b),
    .CLOSE_BTN_IN(close_b), .MOVE_CMD_IN(move_b), .SAFETY_FAIL_IN(fail), .FAULT_CAT_IN(fcat),
    .MANOEUVRE_START_IN(start), .MANOEUVRE_OPENING_IN(opening), .MANOEUVRE_ACTIVE_IN(active),
    .MANOEUVRE_DONE_IN(done), .MANOEUVRE_RESULT_IN(res), .MAINT_ON_WARN_IN(on_warn),
    .MAINT_ON_AUX_IN(on_aux), .AUX_LOCK_REQ_IN(aux_req), .LEVEL_WRITE_IN(lvl_wr),
    .LEVEL_VALUE_IN(lvl_val), .PROGRAM_LED_OUT(leds), .WARN_LAMP_OUT(warn),
    .AUX_LOCK_OUT(aux), .HOLD_RUN_OUT(hold_run), .FACTORY_CLEAR_OUT(fclr),
    .MAINT_LEVEL_OUT(lvl), .MANOEUVRE_COUNT_OUT(cnt), .ANOMALY_FLAGS_OUT(flags));
  panel_operator panel_operator_inst (.clk_in(clk), .set_out(set_b), .open_out(open_b),
    .close_out(close_b), .move_out(move_b));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic int pct(input int c, input int l);
    int t[8] = '{500, 1000, 1500, 2500, 5000, 10000, 15000, 20000};
    return (c * 10 / t[l] > 15) ? 15 : c * 10 / t[l];
  endfunction
  function automatic logic probe(input int n);
    return (n == 8) ? warn : (n == 9) ? aux : leds[n[2:0]];
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic edges(input int n, input int w, output int ri, output int fa);
    logic p;
    ri = 0;
    fa = 0;
    repeat (w)
    begin
      p = probe(n);
      cyc(1);
      ri += int'(!p && probe(n));
      fa += int'(p && !probe(n));
    end
  endtask
  task automatic orled(input int n);
    o = 8'h00;
    repeat (n)
    begin
      cyc(1);
      o |= leds;
    end
  endtask
  task automatic wr_lvl(input logic [2:0] l);
    lvl_val = l;
    lvl_wr = 1'b1;
    cyc(1);
    lvl_wr = 1'b0;
    check(lvl, l);
  endtask
  task automatic moves(input int n);
    repeat (n)
    begin
      res = fault_cat_t'(($urandom_range(0, 3) == 0) ? $urandom_range(1, 9) : 0);
      {active, opening, start, done} = {3'($urandom), 1'b1};
      ef = {ef[6:0], res != 4'h0};
      ec++;
      cyc(1);
      {active, start, done} = 3'h0;
      check(flags, ef);
      check(cnt, ec);
      cyc(1);
    end
  endtask
  task automatic view(input int l);
    wr_lvl(3'(l));
    panel_operator_inst.press(S, HLD + 4, 4'h0);
    orled(10);
    check(o, 8'h01);
    panel_operator_inst.press(C, 1, 4'h0);
    panel_operator_inst.press(C, 1, 4'h0);
    orled(10);
    check(o, 8'h40);
    panel_operator_inst.press(S, HLD + 4, S);
    check(leds, 8'h01 << l);
    panel_operator_inst.press(S | O | C, 1, S);
    edges(l, 80, r, f);
    check(f, pct(ec, l));
    check(leds, 8'h01 << l);
    panel_operator_inst.press(4'h0, 1, 4'h0);
    panel_operator_inst.press(O, 1, 4'h0);
    panel_operator_inst.press(S, 1, 4'h0);
    cyc(3);
    check(leds, 8'h00);
  endtask
  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    fails++;
    results();
  end
  initial
  begin
    {rst, fail, start, opening, active, done, on_warn, on_aux, aux_req, lvl_wr} = 10'h200;
    {fcat, res, lvl_val, ef, ec, fails, total_checks} = '0;
    k = $urandom(91064);
    cyc(2);
    rst = 1'b0;
    cyc(1);
    check({leds, flags, cnt}, 32'h0);
    check(lvl, 3'h5);
    repeat (20)
    begin
      aux_req = 1'($urandom_range(0, 1));
      cyc(1);
      check(aux, aux_req);
    end
    aux_req = 1'b0;
    wr_lvl(3'h0);
    moves(100);
    // role swap: indicator only on the output given the role
    for (int i = 0; i < 2; i++)
    begin
      on_warn = 1'(i);
      on_aux = 1'(1 - i);
      {start, opening} = 2'h3;
      cyc(1);
      start = 1'b0;
      cyc(4);
      check({warn, aux}, {1'(i), 1'(1 - i)});
      cyc(LIT);
      check({warn, aux}, 2'h0);
    end
    {on_aux, on_warn, opening, start} = 4'h9;
    cyc(1);
    start = 1'b0;
    cyc(4);
    check(aux, 1'b0);
    moves(320);
    active = 1'b1;
    edges(9, 24, r, f);
    check(r > 1, 1);
    active = 1'b0;
    cyc(2);
    edges(9, 24, r, f);
    check(r + f, 0);
    moves(90);
    edges(9, 24, r, f);
    check(r > 1, 1);
    for (int l = 7; l >= 0; l--) view(l);
    fail = 1'b1;
    panel_operator_inst.press(M, 1, 4'h0);
    cyc(40);
    panel_operator_inst.press(M, DLY + 5, M);
    check(hold_run, 1'b0);
    panel_operator_inst.press(4'h0, 40, 4'h0);
    panel_operator_inst.press(M, 1, 4'h0);
    cyc(1);
    panel_operator_inst.press(M, DLY + 5, M);
    check(hold_run, 1'b1);
    panel_operator_inst.press(4'h0, 1, 4'h0);
    check(hold_run, 1'b0);
    repeat (3)
    begin
      fail = 1'b0;
      cyc(3);
      fcat = fault_cat_t'($urandom_range(1, 9));
      fail = 1'b1;
      edges(8, 2 * (10 + 4 * int'(fcat)) + 5, r, f);
      check(r, 2 * int'(fcat));
    end
    fail = 1'b0;
    cyc(3);
    panel_operator_inst.press(O | C, HLD + 5, O | C);
    check(leds, 8'hFF);
    panel_operator_inst.press(4'h0, 1, 4'h0);
    k = 0;
    repeat (4)
    begin
      k += int'(fclr === 1'b1);
      cyc(1);
    end
    check(k, 1);
    check({lvl, flags, cnt}, {3'h5, 8'h00, 16'(ec)});
    edges(0, 24, r, f);
    check(r > 4, 1);
    cyc(15);
    check(leds, 8'h00);
    results();
  end
endmodule
